// ### hw/sss_pkg.sv
// package: constants and carrier types for the synchronous burst sram control block
`default_nettype none
package sss_pkg;
    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int ADDR_W_DEF = 19;
    localparam int DATA_W_DEF = 36;
    localparam int BURST_W    = 2;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic       ORDER_LINEAR      = 1'b0;
    localparam logic       ORDER_INTERLEAVED = 1'b1;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {SSS_IDLE, SSS_READ, SSS_WRITE} sss_op_e;

    typedef struct packed {
        logic chip_select_one_n;
        logic chip_select_two;
        logic chip_select_three_n;
    } sss_sel_s;

    typedef struct packed {
        logic write_n;
        logic load;
        logic burst_order;
    } sss_ctl_s;
endpackage
`default_nettype wire

// ### hw/sss_burst_seq.sv
// burst address sequencer: linear or interleaved low-bit order
`timescale 1ns/1ps
`default_nettype none
module sss_burst_seq #(
    parameter int BW = 2
) (
    // start and step
    input  wire logic [BW-1:0] start,
    input  wire logic [BW-1:0] step,
    input  wire logic          interleaved,
    // result
    output logic      [BW-1:0] low_addr
);
    always_comb begin
        if (interleaved) begin
            low_addr = start ^ step;
        end else begin
            low_addr = BW'(start + step);
        end
    end
endmodule // sss_burst_seq
`default_nettype wire

// ### hw/sss_top.sv
// synchronous flow-through burst sram: select, burst order, stall and sleep control
// Behaviour
// - selected only when one low, two high, three low
// - burst order linear on 0, interleaved on 1
// - qualify deasserted: edge ignored, no write
// - data lines stay high impedance leaving sleep until a selected read is loaded
// - sleep high preserves the memory array
`timescale 1ns/1ps
`default_nettype none
module sss_top #(
    parameter int ADDR_W = sss_pkg::ADDR_W_DEF,
    parameter int DATA_W = sss_pkg::DATA_W_DEF
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // select and control pins
    input  wire sss_pkg::sss_sel_s sel_pin,
    input  wire sss_pkg::sss_ctl_s ctl_pin,
    input  wire logic              clock_qualify_n,
    input  wire logic              sleep_request,
    // address and data
    input  wire logic [ADDR_W-1:0] addr_pin,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    // status
    output logic                   asleep
);
    // ****************************************
    // checks and pin synchronisers
    // ****************************************
    localparam int BW = sss_pkg::BURST_W;
    localparam int DEPTH = 1 << ADDR_W;

    if (ADDR_W < BW + 1 || ADDR_W > 20) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    if (DATA_W < 1) begin : g_bad_data_w
        $error("DATA_W out of range");
    end

    localparam int PW = 8 + ADDR_W + DATA_W;
    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {sel_pin, ctl_pin, clock_qualify_n, sleep_request, addr_pin, data_in};
            sync2 <= sync1;
        end
    end

    sss_pkg::sss_sel_s sel;
    sss_pkg::sss_ctl_s ctl;
    logic              cq_n;
    logic              sleep_in;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    assign {sel, ctl, cq_n, sleep_in, addr, din} = sync2;

    // ****************************************
    // decode
    // ****************************************
    logic selected;
    logic enabled;
    assign selected = !sel.chip_select_one_n && sel.chip_select_two
                      && !sel.chip_select_three_n;
    // stall: edge ignored entirely; sleep also blocks the edge but forces op to SSS_IDLE and data_oe low
    assign enabled = !cq_n && !sleep_in;

    // ****************************************
    // state
    // ****************************************
    logic [DATA_W-1:0] mem [DEPTH];
    sss_pkg::sss_op_e  op, next_op;
    logic [ADDR_W-1:0] base, next_base;
    logic [BW-1:0]     count, next_count;
    logic              order, next_order;
    logic [DATA_W-1:0] next_data_out;
    logic              next_data_oe;
    logic              next_asleep;
    logic [BW-1:0]     low_addr;
    logic [ADDR_W-1:0] cur_addr;
    logic [BW-1:0]     next_low;
    logic [ADDR_W-1:0] next_addr;

    sss_burst_seq #(.BW(BW)) u_seq (
        .start       (base[BW-1:0]),
        .step        (count),
        .interleaved (order),
        .low_addr    (low_addr)
    );
    assign cur_addr = {base[ADDR_W-1:BW], low_addr};

    // flow-through: the word shown after an edge is the one that edge moves to
    sss_burst_seq #(.BW(BW)) u_seq_next (
        .start       (next_base[BW-1:0]),
        .step        (next_count),
        .interleaved (next_order),
        .low_addr    (next_low)
    );
    assign next_addr = {next_base[ADDR_W-1:BW], next_low};

    always_comb begin
        next_op       = op;
        next_base     = base;
        next_count    = count;
        next_order    = order;
        next_data_oe  = data_oe;
        next_asleep   = sleep_in;
        if (sleep_in) begin
            next_op      = sss_pkg::SSS_IDLE;
            next_data_oe = 1'b0;
        end else if (enabled) begin
            if (ctl.load) begin
                if (selected) begin
                    next_op    = ctl.write_n ? sss_pkg::SSS_READ : sss_pkg::SSS_WRITE;
                    next_base  = addr;
                    next_count = sss_pkg::BURST_RESET;
                    next_order = ctl.burst_order;
                end else begin
                    next_op = sss_pkg::SSS_IDLE;
                end
            end else if (op != sss_pkg::SSS_IDLE) begin
                next_count = BW'(count + 1'b1);
            end
            next_data_oe = (next_op == sss_pkg::SSS_READ);
        end
    end

    // read data kept apart so the address path does not loop back into itself
    always_comb begin
        next_data_out = data_out;
        if (enabled && next_op == sss_pkg::SSS_READ) begin
            next_data_out = mem[next_addr];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op       <= sss_pkg::SSS_IDLE;
            base     <= '0;
            count    <= sss_pkg::BURST_RESET;
            order    <= sss_pkg::ORDER_LINEAR;
            data_out <= '0;
            data_oe  <= 1'b0;
            asleep   <= 1'b0;
        end else begin
            op       <= next_op;
            base     <= next_base;
            count    <= next_count;
            order    <= next_order;
            data_out <= next_data_out;
            data_oe  <= next_data_oe;
            asleep   <= next_asleep;
        end
    end

    // array has no reset; contents survive sleep and stalls
    always_ff @(posedge clk) begin
        if (enabled && op == sss_pkg::SSS_WRITE) begin
            mem[cur_addr] <= din;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_NO_OE_ASLEEP: assert property (@(posedge clk) disable iff (!reset_n)
        $past(sleep_in) |-> !data_oe) else $error("data driven in sleep");
    AST_STALL_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        (cq_n && !sleep_in) |=> ($stable(count) && $stable(op) && $stable(data_out)))
        else $error("state moved in stall");
    AST_DESEL_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
        (enabled && ctl.load && !selected) |=> op == sss_pkg::SSS_IDLE)
        else $error("deselect not honoured");
    AST_SEL_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
        (enabled && ctl.load && selected) |=> op != sss_pkg::SSS_IDLE)
        else $error("select not honoured");
    AST_ORDER: assert property (@(posedge clk) disable iff (!reset_n)
        (enabled && ctl.load && selected) |=> order == $past(ctl.burst_order))
        else $error("burst order not latched");
    AST_STALL_BASE: assert property (@(posedge clk) disable iff (!reset_n)
        cq_n |=> $stable(base)) else $error("address moved in stall");
    AST_SLEEP_STATUS: assert property (@(posedge clk) disable iff (!reset_n)
        sleep_in |=> asleep ##0 op == sss_pkg::SSS_IDLE) else $error("sleep not entered");
    AST_WAKE_HIZ: assert property (@(posedge clk) disable iff (!reset_n)
        ($fell(sleep_in) && cq_n) |=> !data_oe) else $error("drove on wake in stall");
endmodule // sss_top
`default_nettype wire

// ### verif/sss_host_model.sv
// controller model: drives the select, control, address and data pins
`timescale 1ns/1ps
`default_nettype none
module sss_host_model #(
    parameter int AW = 8,
    parameter int DW = 36
) (
    // clock
    input  wire logic             clk,
    // pins toward the device
    output var sss_pkg::sss_sel_s sel_pin,
    output var sss_pkg::sss_ctl_s ctl_pin,
    output var logic              clock_qualify_n,
    output var logic              sleep_request,
    output var logic [AW-1:0]     addr_pin,
    output var logic [DW-1:0]     data_in
);
    // sleep has no default inside the device, so it is never left floating
    initial begin
        sel_pin = 3'h4;
        ctl_pin = 3'h4;
        clock_qualify_n = 1'b0;
        sleep_request = 1'b0;
        addr_pin = '0;
        data_in = '0;
    end
    // one request held for n edges so it clears the input synchronisers
    task automatic drive(input logic [2:0] s, input logic [2:0] c, input logic q,
                         input logic [AW-1:0] a, input logic [DW-1:0] d, input int n);
        @(posedge clk);
        sel_pin <= s;
        ctl_pin <= c;
        clock_qualify_n <= q;
        addr_pin <= a;
        data_in <= d;
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic qualify(input logic q);
        clock_qualify_n <= q;
    endtask
    task automatic doze(input logic v, input int n);
        @(posedge clk);
        sleep_request <= v;
        repeat (n - 1) @(posedge clk);
    endtask
endmodule // sss_host_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench: select decode, burst order, stall and sleep
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int AW = 8;
    localparam int DW = 36;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    sss_pkg::sss_sel_s sel_pin;
    sss_pkg::sss_ctl_s ctl_pin;
    logic              clock_qualify_n;
    logic              sleep_request;
    logic [AW-1:0]     addr_pin;
    logic [DW-1:0]     data_in;
    logic [DW-1:0]     data_out;
    logic              data_oe;
    logic              asleep;
    int                error_cnt = 0;
    int                tests_run = 0;
    int                k;
    always #5 clk = ~clk;
    sss_host_model #(.AW(AW), .DW(DW)) i_host (.clk(clk), .sel_pin(sel_pin),
        .ctl_pin(ctl_pin), .clock_qualify_n(clock_qualify_n),
        .sleep_request(sleep_request), .addr_pin(addr_pin), .data_in(data_in));
    sss_top #(.ADDR_W(AW), .DATA_W(DW)) i_dut (.clk(clk), .reset_n(reset_n),
        .sel_pin(sel_pin), .ctl_pin(ctl_pin), .clock_qualify_n(clock_qualify_n),
        .sleep_request(sleep_request), .addr_pin(addr_pin), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .asleep(asleep));
    function automatic logic [DW-1:0] pat(input logic [AW-1:0] a);
        return {28'ha5c3e1b, a};
    endfunction
    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a deselected load ends any burst still in flight
    task automatic idle(input int n);
        i_host.drive(3'h4, 3'h6, 1'b0, '0, '0, n);
    endtask
    // write data lags the address by one edge, so it is held past the deselect
    task automatic wr(input logic [AW-1:0] a, input logic q);
        i_host.drive(3'h2, 3'h2, q, a, pat(a) ^ {DW{q}}, 4);
        i_host.drive(3'h4, 3'h6, q, a, pat(a) ^ {DW{q}}, 3);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [2:0] c);
        i_host.drive(3'h2, c, 1'b0, a, '0, 5);
        #1;
        check(data_oe, 1'b1);
        check(data_out, pat(a));
    endtask
    task automatic burst(input logic o);
        int i;
        logic [1:0] j;
        rd(8'h11, {2'b11, o});
        i_host.drive(3'h2, {2'b10, o}, 1'b0, 8'h11, '0, 1);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            if (data_out !== pat(8'h11)) break;
        end
        if (i == 8) begin
            error_cnt++;
            results();
        end
        check(i, 2);
        check(data_out, pat({6'h4, o ? 2'h0 : 2'h2}));
        // stall reaches the core three edges after the pin: edges 3 to 5 hold
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (i == 0 || i == 3) i_host.qualify(i == 0);
            #1;
            j = (i < 2) ? 2'(i + 2) : (i < 6) ? 2'h0 : 2'(i - 5);
            check(data_out, pat({6'h4, o ? 2'h1 ^ j : 2'h1 + j}));
        end
        idle(3);
        $display("burst test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        for (k = 0; k < 4; k++) wr(8'h10 + k[7:0], 1'b0);
        wr(8'h20, 1'b0);
        wr(8'h20, 1'b1);
        idle(3);
        rd(8'h20, 3'h6);
        $display("stall write test done");
        for (k = 0; k < 8; k++) begin
            i_host.drive(k[2:0], 3'h6, 1'b0, 8'h11, '0, 5);
            #1;
            check(data_oe, k == 2);
        end
        idle(3);
        $display("select test done");
        burst(1'b0);
        burst(1'b1);
        i_host.doze(1'b1, 6);
        #1;
        check({asleep, data_oe}, 2'b10);
        i_host.doze(1'b0, 1);
        idle(6);
        #1;
        check({asleep, data_oe}, 2'b00);
        rd(8'h12, 3'h6);
        $display("sleep test done");
        results();
    end
endmodule // testbench
`default_nettype wire
